// ---- host_port_defines.svh ----
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define HP_ADDR_W 11
`define HP_DATA_W 16
`define HP_REG_W 32
`define HP_UPPER_LSB 16

// ----------------------------------------------------------------
// wait/ready low-time limits in bus clocks
// ----------------------------------------------------------------
`define HP_RDY_READ_MAX_FAST 5
`define HP_RDY_WRITE_MAX_FAST_ORIG 4
`define HP_RDY_WRITE_MAX_FAST 5
`define HP_RDY_READ_MAX_SLOW 7
`define HP_RDY_WRITE_MAX_SLOW_ORIG 6
`define HP_RDY_WRITE_MAX_SLOW 7

`endif

// ---- host_port_pkg.sv ----
package host_port_pkg;

    typedef enum logic [1:0] {
        rising_edge_bus_mode = 2'h0,
        falling_edge_bus_mode = 2'h1,
        third_host_mode = 2'h2
    } bus_mode_t;

    typedef enum logic [1:0] {
        link_idle = 2'h0,
        link_wait = 2'h1,
        link_done = 2'h2
    } link_state_t;

endpackage : host_port_pkg

// ---- reg_store_if.sv ----
`timescale 1ns/1ps
`include "host_port_defines.svh"

interface reg_store_if #(
    parameter int ADDR_W = `HP_ADDR_W,
    parameter int REG_W = `HP_REG_W
);
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata;
    logic [REG_W-1:0] rdata;

    modport core (output wr_en, output addr, output wdata, input rdata);
    modport store (input wr_en, input addr, input wdata, output rdata);
endinterface : reg_store_if

// ---- reg_store.sv ----
`timescale 1ns/1ps
`include "host_port_defines.svh"

module reg_store #(
    parameter int ADDR_W = `HP_ADDR_W,
    parameter int REG_W = `HP_REG_W
) (
    input wire logic clk,
    reg_store_if.store bus
);
    logic [REG_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [REG_W-1:0] rdata;

    // read data comes from a register, one cycle after the address
    always_ff @(posedge clk)
    begin
        if (bus.wr_en)
        begin
            mem[bus.addr] <= bus.wdata;
        end
        rdata <= mem[bus.addr];
    end

    assign bus.rdata = rdata;

endmodule : reg_store

// ---- host_bus_port.sv ----
`timescale 1ns/1ps
`include "host_port_defines.svh"

// Overview of operation
// - each 32-bit register is reached by two back-to-back 16-bit accesses
// - separate 11-bit address bus and 16-bit data bus
// - rising mode: read stalls with ready low at next rising edge
// - rising mode: ready rises on rising edge with valid read data
// - falling mode: read ready low and later high on falling edges
// - rising and falling modes: data bus floats once read strobe goes high
// - third mode: ready low at falling edge, data on falling, ready high on rising
// - third mode: data bus floats when chip select or read strobe rises
// - rising mode: write data captured at next rising edge, ready low
// - falling and third modes: write data captured at next falling edge
// - second write keeps ready low until the target register is updated
// - third mode: write ready rises at rising edge after update
// - ready low at most 5 bus clocks at the fast internal clock
// - ready low at most 7 bus clocks at the slow internal clock
// - first read loads whole register, returns upper half; second returns lower
// - first write fills upper half, second lower, then commit

module host_bus_port #(
    parameter host_port_pkg::bus_mode_t BUS_MODE = host_port_pkg::rising_edge_bus_mode,
    parameter int ADDR_W = `HP_ADDR_W,
    parameter int DATA_W = `HP_DATA_W,
    parameter int REG_W = `HP_REG_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic bclk,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic rdy
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (REG_W != 2 * DATA_W)
    begin : g_bad_width
        $error("register width must be twice the data bus width");
    end
    if (ADDR_W < 1 || ADDR_W > 16)
    begin : g_bad_addr
        $error("address width out of range");
    end
    if (BUS_MODE != host_port_pkg::rising_edge_bus_mode &&
        BUS_MODE != host_port_pkg::falling_edge_bus_mode &&
        BUS_MODE != host_port_pkg::third_host_mode)
    begin : g_bad_mode
        $error("unknown bus mode");
    end

    // ----------------------------------------------------------------
    // link clock selection
    // ----------------------------------------------------------------
    // mode is a build-time choice, so the inversion is a fixed clock edge
    logic link_clk;
    if (BUS_MODE == host_port_pkg::rising_edge_bus_mode)
    begin : g_rise_clk
        assign link_clk = bclk;
    end
    else
    begin : g_fall_clk
        assign link_clk = ~bclk;
    end

    // ----------------------------------------------------------------
    // link reset
    // ----------------------------------------------------------------
    logic link_rst_meta;
    logic link_rst;
    logic next_link_rst_meta;
    logic next_link_rst;

    always_comb
    begin
        next_link_rst_meta = rst;
        next_link_rst = link_rst_meta;
    end

    always_ff @(posedge link_clk)
    begin
        link_rst_meta <= next_link_rst_meta;
        link_rst <= next_link_rst;
    end

    // ----------------------------------------------------------------
    // crossing signals
    // ----------------------------------------------------------------
    logic req_tgl;
    logic req_wr;
    logic [ADDR_W-1:0] req_addr;
    logic [REG_W-1:0] wr_hold;
    logic ack_tgl;
    logic [REG_W-1:0] rd_cross;

    // ----------------------------------------------------------------
    // link side state machine
    // ----------------------------------------------------------------
    host_port_pkg::link_state_t state;
    host_port_pkg::link_state_t next_state;
    logic rd_half;
    logic next_rd_half;
    logic wr_half;
    logic next_wr_half;
    logic local_done;
    logic next_local_done;
    logic cur_read;
    logic next_cur_read;
    logic next_req_tgl;
    logic next_req_wr;
    logic [ADDR_W-1:0] next_req_addr;
    logic [REG_W-1:0] next_wr_hold;
    logic [REG_W-1:0] rd_temp;
    logic [REG_W-1:0] next_rd_temp;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] next_dout;
    logic rdy_link;
    logic next_rdy_link;
    logic ack_meta;
    logic ack_sync;
    logic ack_last;
    logic next_ack_meta;
    logic next_ack_sync;
    logic next_ack_last;
    logic ack_new;
    logic rd_go;
    logic wr_go;
    logic released;

    assign ack_new = ack_sync ^ ack_last;
    assign rd_go = !cs_n && !rd_n;
    assign wr_go = !cs_n && !wr_n && rd_n;
    assign released = cs_n || (rd_n && wr_n);

    always_comb
    begin
        next_state = state;
        next_rd_half = rd_half;
        next_wr_half = wr_half;
        next_local_done = local_done;
        next_cur_read = cur_read;
        next_req_tgl = req_tgl;
        next_req_wr = req_wr;
        next_req_addr = req_addr;
        next_wr_hold = wr_hold;
        next_rd_temp = rd_temp;
        next_dout = dout;
        next_rdy_link = rdy_link;
        next_ack_meta = ack_tgl;
        next_ack_sync = ack_meta;
        next_ack_last = ack_sync;
        unique case (state)
            host_port_pkg::link_idle:
            begin
                if (rd_go)
                begin
                    next_rdy_link = 1'b0;
                    next_cur_read = 1'b1;
                    next_state = host_port_pkg::link_wait;
                    if (!rd_half)
                    begin
                        // first half fetches the whole register
                        next_req_wr = 1'b0;
                        next_req_addr = addr;
                        next_req_tgl = ~req_tgl;
                        next_local_done = 1'b0;
                    end
                    else
                    begin
                        next_local_done = 1'b1;
                    end
                end
                else if (wr_go)
                begin
                    next_rdy_link = 1'b0;
                    next_cur_read = 1'b0;
                    next_state = host_port_pkg::link_wait;
                    if (!wr_half)
                    begin
                        next_wr_hold[REG_W-1:`HP_UPPER_LSB] = data_in;
                        next_local_done = 1'b1;
                    end
                    else
                    begin
                        next_wr_hold[`HP_UPPER_LSB-1:0] = data_in;
                        next_req_wr = 1'b1;
                        next_req_addr = addr;
                        next_req_tgl = ~req_tgl;
                        next_local_done = 1'b0;
                    end
                end
            end
            host_port_pkg::link_wait:
            begin
                // worst path is two syncs plus one store access, within 5 bus clocks
                if (local_done || ack_new)
                begin
                    next_rdy_link = 1'b1;
                    next_state = host_port_pkg::link_done;
                    if (cur_read)
                    begin
                        next_rd_half = ~rd_half;
                        if (!rd_half)
                        begin
                            next_rd_temp = rd_cross;
                            next_dout = rd_cross[REG_W-1:`HP_UPPER_LSB];
                        end
                        else
                        begin
                            next_dout = rd_temp[`HP_UPPER_LSB-1:0];
                        end
                    end
                    else
                    begin
                        next_wr_half = ~wr_half;
                    end
                end
            end
            host_port_pkg::link_done:
            begin
                if (released)
                begin
                    next_state = host_port_pkg::link_idle;
                end
            end
            default:
            begin
                next_state = host_port_pkg::link_idle;
            end
        endcase
    end

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            state <= host_port_pkg::link_idle;
            rd_half <= 1'b0;
            wr_half <= 1'b0;
            local_done <= 1'b0;
            cur_read <= 1'b0;
            req_tgl <= 1'b0;
            req_wr <= 1'b0;
            req_addr <= '0;
            wr_hold <= '0;
            rd_temp <= '0;
            dout <= '0;
            rdy_link <= 1'b1;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            ack_last <= 1'b0;
        end
        else
        begin
            state <= next_state;
            rd_half <= next_rd_half;
            wr_half <= next_wr_half;
            local_done <= next_local_done;
            cur_read <= next_cur_read;
            req_tgl <= next_req_tgl;
            req_wr <= next_req_wr;
            req_addr <= next_req_addr;
            wr_hold <= next_wr_hold;
            rd_temp <= next_rd_temp;
            dout <= next_dout;
            rdy_link <= next_rdy_link;
            ack_meta <= next_ack_meta;
            ack_sync <= next_ack_sync;
            ack_last <= next_ack_last;
        end
    end

    // ----------------------------------------------------------------
    // pin outputs
    // ----------------------------------------------------------------
    assign data_out = dout;
    // floats as soon as either strobe side lets go
    assign data_oe_n = cs_n || rd_n;

    if (BUS_MODE == host_port_pkg::third_host_mode)
    begin : g_third_rdy
        logic rdy_rise;
        logic next_rdy_rise;
        always_comb
        begin
            next_rdy_rise = rdy_link;
        end
        // half a cycle after the falling-edge release, on the rising edge
        always_ff @(posedge bclk)
        begin
            if (link_rst)
            begin
                rdy_rise <= 1'b1;
            end
            else
            begin
                rdy_rise <= next_rdy_rise;
            end
        end
        assign rdy = rdy_link && rdy_rise;
    end
    else
    begin : g_plain_rdy
        assign rdy = rdy_link;
    end

    // ----------------------------------------------------------------
    // core side
    // ----------------------------------------------------------------
    reg_store_if #(.ADDR_W(ADDR_W), .REG_W(REG_W)) store_bus ();

    logic req_meta;
    logic req_sync;
    logic req_last;
    logic next_req_meta;
    logic next_req_sync;
    logic next_req_last;
    logic pend;
    logic next_pend;
    logic next_ack_tgl;
    logic [REG_W-1:0] next_rd_cross;
    logic req_new;

    assign req_new = req_sync ^ req_last;

    always_comb
    begin
        next_req_meta = req_tgl;
        next_req_sync = req_meta;
        next_req_last = req_sync;
        next_pend = 1'b0;
        next_ack_tgl = ack_tgl;
        next_rd_cross = rd_cross;
        // payload is stable in the link domain while the toggle is in flight
        store_bus.addr = req_addr;
        store_bus.wdata = wr_hold;
        store_bus.wr_en = req_new && req_wr;
        if (req_new)
        begin
            next_pend = 1'b1;
        end
        if (pend)
        begin
            next_rd_cross = store_bus.rdata;
            next_ack_tgl = ~ack_tgl;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_last <= 1'b0;
            pend <= 1'b0;
            ack_tgl <= 1'b0;
            rd_cross <= '0;
        end
        else
        begin
            req_meta <= next_req_meta;
            req_sync <= next_req_sync;
            req_last <= next_req_last;
            pend <= next_pend;
            ack_tgl <= next_ack_tgl;
            rd_cross <= next_rd_cross;
        end
    end

    reg_store #(
        .ADDR_W(ADDR_W),
        .REG_W(REG_W)
    ) u_store (
        .clk(clk),
        .bus(store_bus)
    );

endmodule : host_bus_port

// ---- host_port_checker.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port protocol checks, timed on the mode's link edge; the output-enable check runs on clk
// ----------------------------------------------------------------
module host_port_checker #(
    parameter host_port_pkg::bus_mode_t BUS_MODE = host_port_pkg::rising_edge_bus_mode
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic bclk,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [10:0] addr,
    input wire logic [15:0] data_in,
    input wire logic [15:0] data_out,
    input wire logic data_oe_n,
    input wire logic rdy
);
    logic lclk;
    logic prev_rd;
    logic prev_wr;
    logic rd_odd;
    logic wr_odd;
    wire rd_act = !cs_n && !rd_n;
    wire wr_act = !cs_n && !wr_n && rd_n;
    wire rd_go = rd_act && !prev_rd;
    wire wr_go = wr_act && !prev_wr;

    // third mode raises ready on the rising edge; the next falling edge still sees it in time
    if (BUS_MODE == host_port_pkg::rising_edge_bus_mode)
    begin : g_rise_edge
        assign lclk = bclk;
    end
    else
    begin : g_fall_edge
        assign lclk = ~bclk;
    end

    // half trackers mirror the pairing, so local halves can be timed
    always_ff @(posedge lclk)
    begin
        if (rst)
        begin
            prev_rd <= 1'h0;
            prev_wr <= 1'h0;
            rd_odd <= 1'h0;
            wr_odd <= 1'h0;
        end
        else
        begin
            prev_rd <= rd_act;
            prev_wr <= wr_act;
            rd_odd <= rd_odd ^ rd_go;
            wr_odd <= wr_odd ^ wr_go;
        end
    end

    a_oe_tracks: assert property (@(posedge clk) disable iff (rst) data_oe_n == (cs_n | rd_n))
        else $error("output enable does not follow the strobes");
    a_read_stall: assert property (@(posedge lclk) disable iff (rst) rd_go |=> !rdy)
        else $error("read did not stall");
    a_write_stall: assert property (@(posedge lclk) disable iff (rst) wr_go |=> !rdy)
        else $error("write did not stall");
    a_low_bound: assert property (@(posedge lclk) disable iff (rst) $fell(rdy) |-> ##[1:5] rdy)
        else $error("ready held low too long");
    a_fell_cause: assert property (@(posedge lclk) disable iff (rst) $fell(rdy) |-> $past(rd_act || wr_act))
        else $error("ready fell without an access");
    a_read_hold: assert property (@(posedge lclk) disable iff (rst)
        rdy && $past(rdy) && rd_act && $past(rd_act) |-> $stable(data_out))
        else $error("read data moved while ready");
    a_idle_ready: assert property (@(posedge lclk) disable iff (rst) cs_n && rdy |=> rdy)
        else $error("ready dropped while deselected");
    a_second_read: assert property (@(posedge lclk) disable iff (rst) rd_go && rd_odd |=> !rdy ##1 rdy)
        else $error("second read half not answered locally");
    a_first_write: assert property (@(posedge lclk) disable iff (rst) wr_go && !wr_odd |=> !rdy ##1 rdy)
        else $error("first write half not answered locally");
endmodule : host_port_checker

// ---- host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host bus master
// ----------------------------------------------------------------
module host_model (
    output logic bclk,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [10:0] addr,
    output logic [15:0] data_in,
    input wire logic [15:0] data_out,
    input wire logic data_oe_n,
    input wire logic rdy
);
    // bus clock runs free; 2.5 ns offset keeps its edges off clk edges
    initial
    begin
        bclk = 1'h0;
        cs_n = 1'h1;
        rd_n = 1'h1;
        wr_n = 1'h1;
        addr = 11'h000;
        data_in = 16'h0000;
        #2.5;
        forever #32 bclk = ~bclk;
    end

    // one 16-bit access; address and data ride separate lines
    task automatic access(input logic rd, input logic [10:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic oe_n);
        int n;
        @(negedge bclk);
        cs_n <= 1'h0;
        rd_n <= !rd;
        wr_n <= rd;
        addr <= a;
        data_in <= rd ? ~data_in : d;
        @(posedge bclk);
        n = 0;
        do
        begin
            @(posedge bclk);
            n++;
        end
        while (rdy !== 1'h1 && n < 20);
        // a stuck wait counts against the run
        if (rdy !== 1'h1)
            host_bus_port_tb.err_count++;
        q = data_out;
        oe_n = data_oe_n;
        @(negedge bclk);
        // released lines show inverted junk, not the last value
        cs_n <= 1'h1;
        rd_n <= 1'h1;
        wr_n <= 1'h1;
        addr <= ~a;
        data_in <= ~data_in;
    endtask : access

    task automatic strobe_no_cs(input int n, output logic ok);
        @(negedge bclk);
        rd_n <= 1'h0;
        wr_n <= 1'h0;
        ok = 1'h1;
        repeat (n)
        begin
            @(posedge bclk);
            #1;
            if (rdy !== 1'h1 || data_oe_n !== 1'h1)
                ok = 1'h0;
        end
        @(negedge bclk);
        rd_n <= 1'h1;
        wr_n <= 1'h1;
    endtask : strobe_no_cs
endmodule : host_model

// ---- host_bus_port_tb.sv ----
`timescale 1ns/1ps
module host_bus_port_tb;
    logic clk;
    logic rst;
    wire [2:0] data_oe_n;
    int err_count;
    int check_count;

    // one port and one host per bus timing mode, sharing clk and rst
    for (genvar m = 0; m < 3; m++)
    begin : g_mode
        wire bclk;
        wire cs_n;
        wire rd_n;
        wire wr_n;
        wire [10:0] addr;
        wire [15:0] data_in;
        wire [15:0] data_out;
        wire rdy;
        host_bus_port #(.BUS_MODE(host_port_pkg::bus_mode_t'(m))) u_host_bus_port (.clk(clk), .rst(rst),
            .bclk(bclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
            .data_out(data_out), .data_oe_n(data_oe_n[m]), .rdy(rdy));
        host_model u_host_model (.bclk(bclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
            .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n[m]), .rdy(rdy));
    end

    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // host tasks live in the generate scopes, so each mode is picked by hand
    task automatic host_access(input int m, input logic rd, input logic [10:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic oe_n);
        case (m)
            0: g_mode[0].u_host_model.access(rd, a, d, q, oe_n);
            1: g_mode[1].u_host_model.access(rd, a, d, q, oe_n);
            default: g_mode[2].u_host_model.access(rd, a, d, q, oe_n);
        endcase
    endtask : host_access

    task automatic host_strobe(input int m, input int n, output logic ok);
        case (m)
            0: g_mode[0].u_host_model.strobe_no_cs(n, ok);
            1: g_mode[1].u_host_model.strobe_no_cs(n, ok);
            default: g_mode[2].u_host_model.strobe_no_cs(n, ok);
        endcase
    endtask : host_strobe

    task automatic wr32(input int m, input logic [10:0] a1, input logic [10:0] a2, input logic [31:0] v);
        logic [15:0] q;
        logic o;
        host_access(m, 1'h0, a1, v[31:16], q, o);
        host_access(m, 1'h0, a2, v[15:0], q, o);
    endtask : wr32

    task automatic rd32(input int m, input logic [10:0] a1, input logic [10:0] a2, input logic [31:0] v);
        logic [15:0] q;
        logic o;
        host_access(m, 1'h1, a1, 16'h0000, q, o);
        check(q, v[31:16]);
        check({15'h0000, o}, 16'h0000);
        host_access(m, 1'h1, a2, 16'h0000, q, o);
        check(q, v[15:0]);
        #1;
        check({15'h0000, data_oe_n[m]}, 16'h0001);
    endtask : rd32

    task automatic t_pair_basic(input int m);
        wr32(m, 11'h005, 11'h005, 32'hA5C3_1E7F);
        rd32(m, 11'h005, 11'h005, 32'hA5C3_1E7F);
    endtask : t_pair_basic

    // commit goes to the second address; second read address is unused
    task automatic t_commit_addr(input int m);
        wr32(m, 11'h010, 11'h7FF, 32'h0F1E_2D3C);
        wr32(m, 11'h000, 11'h000, 32'hFFFF_0000);
        rd32(m, 11'h7FF, 11'h000, 32'h0F1E_2D3C);
        rd32(m, 11'h000, 11'h7FF, 32'hFFFF_0000);
        rd32(m, 11'h005, 11'h010, 32'hA5C3_1E7F);
    endtask : t_commit_addr

    task automatic t_cs_high(input int m);
        logic ok;
        host_strobe(m, 4, ok);
        check({15'h0000, ok}, 16'h0001);
        rd32(m, 11'h7FF, 11'h7FF, 32'h0F1E_2D3C);
    endtask : t_cs_high

    initial
    begin
        err_count = 0;
        check_count = 0;
        // an 80 ns pulse still spans one rising and one falling bus clock edge, enough for the link reset
        rst = 1'h1;
        repeat (8) @(negedge clk);
        rst <= 1'h0;
        repeat (4) @(posedge g_mode[0].bclk);
        for (int m = 0; m < 3; m++)
        begin
            t_pair_basic(m);
            t_commit_addr(m);
            t_cs_high(m);
        end
        test_done;
    end

    initial
    begin
        #100000;
        err_count++;
        test_done;
    end
endmodule : host_bus_port_tb

bind host_bus_port host_port_checker #(.BUS_MODE(BUS_MODE)) u_host_port_checker (.clk(clk), .rst(rst),
    .bclk(bclk), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .rdy(rdy));
